// [odc_pkg.sv]
package odc_pkg;
  // Bus geometry and block sizes.
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;
  localparam int IDX_W    = ADDR_W - 2;
  localparam int NUM_DRV  = 4;
  localparam int NUM_GPIO = 2;
  localparam int NUM_SRC  = 4;
  localparam int ATT_W    = 6;
  localparam int CNT_W    = 32;
  localparam int CLK_MHZ  = 100;
  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_HEADSET    = 10'h00d;
  localparam logic [IDX_W-1:0] IDX_HP_CFG     = 10'h00e;
  localparam logic [IDX_W-1:0] IDX_DAC_PWR    = 10'h025;
  localparam logic [IDX_W-1:0] IDX_SHORT_CTL  = 10'h026;
  localparam logic [IDX_W-1:0] IDX_RAMP       = 10'h028;
  localparam logic [IDX_W-1:0] IDX_PD_CTL     = 10'h02a;
  localparam logic [IDX_W-1:0] IDX_SHORT_STAT = 10'h05f;
  localparam logic [IDX_W-1:0] IDX_REC_FILT   = 10'h06b;
  localparam logic [IDX_W-1:0] IDX_BYPASS     = 10'h06c;
  localparam logic [IDX_W-1:0] IDX_DAC_CUR    = 10'h06d;
  localparam logic [IDX_W-1:0] IDX_HP_PWR     = 10'h040;
  localparam logic [IDX_W-1:0] IDX_GPIO0      = 10'h041;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT   = 10'h043;
  // Field positions.
  localparam int BIT_DAC_L      = 7;
  localparam int BIT_DAC_R      = 6;
  localparam int BIT_SHORT_EN   = 1;
  localparam int BIT_AUTO_OFF   = 2;
  localparam int BIT_RAMP_EN    = 0;
  localparam int BIT_REC_FILT   = 3;
  localparam int DAC_CUR_LSB    = 6;
  localparam int PD_STATE_LSB   = 0;
  localparam int DELAY_LSB      = 4;
  localparam int GPIO_OUT_BIT   = 2;
  localparam int GPIO_TRAIN_BIT = 3;
  localparam int GPIO_MASK_LSB  = 4;
  localparam int GPIO_IN_BIT    = 8;
  // Reset values.
  localparam logic [7:0] RST_HP_CFG    = 8'h01;
  localparam logic [7:0] RST_SHORT_CTL = 8'h02;
  localparam logic [7:0] RST_RAMP      = 8'h01;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  // Interrupt source positions.
  localparam int SRC_JACK   = 0;
  localparam int SRC_BUTTON = 1;
  localparam int SRC_SHORT  = 2;
  localparam int SRC_NOISE  = 3;
  // Headset type codes.
  localparam logic [1:0] HS_NONE   = 2'h0;
  localparam logic [1:0] HS_STEREO = 2'h2;
  localparam logic [1:0] HS_MONO   = 2'h3;
  // Times in microseconds and their cycle counts.
  localparam int PULSE_US     = 2;
  localparam int TRAIN_US     = 20;
  localparam int RAMP_STEP_US = 20;
  localparam int MS_US        = 1000;
  localparam int PULSE_CYC    = PULSE_US * CLK_MHZ;
  localparam int TRAIN_CYC    = TRAIN_US * CLK_MHZ;
  localparam int RAMP_CYC     = RAMP_STEP_US * CLK_MHZ;
  localparam int MS_CYC       = MS_US * CLK_MHZ;
  localparam logic [ATT_W-1:0] RAMP_START = 6'h3f;
  // Power-up delay choices in milliseconds, from none up to four seconds.
  localparam int DELAY_MS [8] = '{0, 1, 10, 50, 100, 500, 1000, 4000};
  // Driver sequencing states.
  typedef enum logic [2:0] {DRV_OFF, DRV_WAIT, DRV_RAMP, DRV_ON, DRV_FAULT} odc_drv_e;
  // Pin function choices.
  typedef enum logic [1:0] {PIN_IN, PIN_OUT, PIN_CLK, PIN_IRQ} odc_pin_e;
  // Headphone output configuration types.
  typedef enum logic [1:0] {CFG_DIFF, CFG_SE, CFG_PSEUDO, CFG_AC} odc_cfg_e;
  // Analog detection inputs.
  typedef struct packed {
    logic               jack;
    logic [1:0]         hs_type;
    logic               button;
    logic               noise;
    logic [NUM_DRV-1:0] short_det;
  } odc_det_s;
  // Driver controls toward the analog stage.
  typedef struct packed {
    logic [NUM_DRV-1:0] en;
    logic [1:0]         pd_state;
    logic [1:0]         cfg_type;
  } odc_hp_s;
  // Passive bypass switch controls; a set bit closes a switch.
  typedef struct packed {
    logic right_neg_in2_switch;
    logic right_pos_in2_switch;
    logic right_neg_in1_switch;
    logic right_pos_in1_switch;
    logic left_neg_in2_switch;
    logic left_pos_in2_switch;
    logic left_neg_in1_switch;
    logic left_pos_in1_switch;
    logic left_pos_normal_switch;
    logic left_neg_normal_switch;
    logic right_pos_normal_switch;
    logic right_neg_normal_switch;
  } odc_byp_s;
endpackage

// [odc_top.sv]
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
// Overview of operation
// - Programmable delay, none to four seconds.
// - Powered-down pins: hi-Z, common mode, half-supply.
// - Optional ramp steps attenuation down to target.
// - Shorts are current-limited and flagged in status.
// - Auto shutdown holds driver off until power-cycled.
// - Jack insertion detected and headset type reported.
// - AC-coupled mode cannot tell mono from stereo.
// - Two pins: input, output, clock or interrupt.
// - Interrupt sources routed singly or ORed, recorded.
// - Interrupt pin gives pulse or train until read.
// - Record-only reuses playback filters and coefficients.
// - Record filter path only while both DACs off.
// - Two-bit DAC bias field, lowest by default.
// - Bypass opens normal switches, closes input ones.
// - Left bypass bits 0 to 3 select inputs.
// - Right bypass bits 4 to 7 select inputs.
module odc_top #(
  parameter int unsigned DELAY_UNIT_CYC = odc_pkg::MS_CYC
) (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [odc_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [odc_pkg::DATA_W-1:0]      pwdata,
  output logic      [odc_pkg::DATA_W-1:0]      prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire odc_pkg::odc_det_s               det,
  input  wire logic [odc_pkg::NUM_GPIO-1:0]    gpio_in,
  input  wire logic                            int_clk,
  output logic      [odc_pkg::NUM_GPIO-1:0]    gpio_out,
  output logic      [odc_pkg::NUM_GPIO-1:0]    gpio_oe,
  output odc_pkg::odc_hp_s                     hp,
  output logic [odc_pkg::NUM_DRV-1:0][odc_pkg::ATT_W-1:0] hp_atten,
  output odc_pkg::odc_byp_s                    bypass_sw,
  output logic                                 record_filter_switch,
  output logic      [1:0]                      dac_bias
);
  import odc_pkg::*;

  // Refuse a delay unit the counter cannot serve.
  if (DELAY_UNIT_CYC < 1 || DELAY_UNIT_CYC > 100000) begin : g_chk
    $error("DELAY_UNIT_CYC out of range");
  end

  logic [IDX_W-1:0]    idx;                       // Word index of the access.
  logic                setup;                     // Setup phase of a transfer.
  logic                acc;                       // Completing access phase.
  logic [7:0]          hs_reg, cfg_reg, dac_pwr;  // Status and control bytes.
  logic [7:0]          sc_ctl, ramp_reg, pd_ctl;  // Short, ramp, powerdown control.
  logic [7:0]          rec_reg, byp_reg, cur_reg; // Record, bypass, bias.
  logic [7:0]          pwr_reg, pwr_q;            // Driver power bits and their last value.
  logic [7:0]          gcfg [NUM_GPIO];           // Pin configuration bytes.
  logic [NUM_SRC-1:0]  irq_stat;                  // Latched interrupt sources.
  logic [NUM_DRV-1:0]  sflag;                     // Sticky short flags.
  logic                jack_q;                    // Last jack level.
  logic [NUM_GPIO-1:0] gin_q;                     // Sampled pin inputs.
  logic [NUM_DRV-1:0]  drv_on;                    // Driver active per driver.
  logic [7:0]          next_hs, next_cfg, next_dac, next_sc, next_ramp, next_pd;
  logic [7:0]          next_rec, next_byp, next_cur, next_pwr;
  logic [7:0]          next_gcfg [NUM_GPIO];
  logic [NUM_SRC-1:0]  next_irq, irq_set;
  logic [NUM_DRV-1:0]  next_sflag, s_set;
  logic [DATA_W-1:0]   next_prdata;
  logic                next_pready, next_pslverr, hit;
  logic [7:0]          rd;
  logic [1:0]          pd_q, cfg_q;               // Registered powered-down state and output type.

  assign idx   = paddr[ADDR_W-1:2];
  assign setup = psel & ~penable;
  assign acc   = psel & penable & pready;

  // Register file, status capture and bus answer, computed for the next edge.
  always_comb begin
    next_cfg  = cfg_reg;
    next_dac  = dac_pwr;
    next_sc   = sc_ctl;
    next_ramp = ramp_reg;
    next_pd   = pd_ctl;
    next_rec  = rec_reg;
    next_byp  = byp_reg;
    next_cur  = cur_reg;
    next_pwr  = pwr_reg;
    for (int p = 0; p < NUM_GPIO; p++) begin
      next_gcfg[p] = gcfg[p];
    end
    // A write takes effect on the completing edge only.
    if (acc && pwrite) begin
      unique case (idx)
        IDX_HP_CFG:    next_cfg  = pwdata[7:0];
        IDX_DAC_PWR:   next_dac  = pwdata[7:0];
        IDX_SHORT_CTL: next_sc   = pwdata[7:0];
        IDX_RAMP:      next_ramp = pwdata[7:0];
        IDX_PD_CTL:    next_pd   = pwdata[7:0];
        IDX_REC_FILT:  next_rec  = pwdata[7:0];
        IDX_BYPASS:    next_byp  = pwdata[7:0];
        IDX_DAC_CUR:   next_cur  = pwdata[7:0];
        IDX_HP_PWR:    next_pwr  = pwdata[7:0];
        default: begin
          for (int p = 0; p < NUM_GPIO; p++) begin
            if (idx == IDX_GPIO0 + IDX_W'(p)) begin
              next_gcfg[p] = pwdata[7:0];
            end
          end
        end
      endcase
    end
    // Short flags are set by a detected short and cleared by a power-up edge; set wins.
    s_set      = det.short_det & {NUM_DRV{sc_ctl[BIT_SHORT_EN]}};
    next_sflag = (sflag & ~(pwr_reg[NUM_DRV-1:0] & ~pwr_q[NUM_DRV-1:0])) | s_set;
    // Interrupt sources latch on their events.
    irq_set             = '0;
    irq_set[SRC_JACK]   = det.jack ^ jack_q;
    irq_set[SRC_BUTTON] = det.button;
    irq_set[SRC_SHORT]  = |(s_set & ~sflag);
    irq_set[SRC_NOISE]  = det.noise;
    // A completed read of the status register clears it; a new event still wins.
    next_irq = irq_stat | irq_set;
    if (acc && !pwrite && idx == IDX_IRQ_STAT) begin
      next_irq = irq_set;
    end
    // Headset type is shown only while a plug is in, except that AC mode shows stereo for a mono input even unplugged.
    next_hs = {6'h00, det.jack ? det.hs_type : HS_NONE};
    // AC-coupled sensing cannot separate mono from stereo, so mono is shown as stereo.
    if (cfg_reg[1:0] == CFG_AC && det.hs_type == HS_MONO) begin
      next_hs = {6'h00, HS_STEREO};
    end
    // Read data is chosen in the setup phase and held for the access phase.
    hit = 1'b1;
    rd  = 8'h00;
    unique case (idx)
      IDX_HEADSET:    rd = hs_reg;
      IDX_HP_CFG:     rd = cfg_reg;
      IDX_DAC_PWR:    rd = dac_pwr;
      IDX_SHORT_CTL:  rd = sc_ctl;
      IDX_RAMP:       rd = ramp_reg;
      IDX_PD_CTL:     rd = pd_ctl;
      IDX_SHORT_STAT: rd = {drv_on, sflag};
      IDX_REC_FILT:   rd = rec_reg;
      IDX_BYPASS:     rd = byp_reg;
      IDX_DAC_CUR:    rd = cur_reg;
      IDX_HP_PWR:     rd = pwr_reg;
      IDX_IRQ_STAT:   rd = {4'h0, irq_stat};
      default: begin
        hit = 1'b0;
        for (int p = 0; p < NUM_GPIO; p++) begin
          if (idx == IDX_GPIO0 + IDX_W'(p)) begin
            hit = 1'b1;
            rd  = gcfg[p];
          end
        end
      end
    endcase
    next_prdata = '0;
    for (int p = 0; p < NUM_GPIO; p++) begin
      if (idx == IDX_GPIO0 + IDX_W'(p)) begin
        next_prdata[GPIO_IN_BIT] = gin_q[p];
      end
    end
    next_prdata[7:0] = rd;
    next_pready      = setup;
    next_pslverr     = setup & ~(hit & paddr[1:0] == 2'h0);
    if (!setup) begin
      next_prdata = prdata;
    end
  end

  // Registers of the control group.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hs_reg   <= RST_ZERO;
      cfg_reg  <= RST_HP_CFG;
      dac_pwr  <= RST_ZERO;
      sc_ctl   <= RST_SHORT_CTL;
      ramp_reg <= RST_RAMP;
      pd_ctl   <= RST_ZERO;
      rec_reg  <= RST_ZERO;
      byp_reg  <= RST_ZERO;
      cur_reg  <= RST_ZERO;
      pwr_reg  <= RST_ZERO;
      pwr_q    <= RST_ZERO;
      for (int p = 0; p < NUM_GPIO; p++) begin
        gcfg[p] <= RST_ZERO;
      end
      irq_stat <= '0;
      sflag    <= '0;
      jack_q   <= 1'b0;
      gin_q    <= '0;
      prdata   <= '0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      hs_reg   <= next_hs;
      cfg_reg  <= next_cfg;
      dac_pwr  <= next_dac;
      sc_ctl   <= next_sc;
      ramp_reg <= next_ramp;
      pd_ctl   <= next_pd;
      rec_reg  <= next_rec;
      byp_reg  <= next_byp;
      cur_reg  <= next_cur;
      pwr_reg  <= next_pwr;
      pwr_q    <= pwr_reg;
      gcfg     <= next_gcfg;
      irq_stat <= next_irq;
      sflag    <= next_sflag;
      jack_q   <= det.jack;
      gin_q    <= gpio_in;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
    end
  end

  // Analog routing controls, all registered.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pd_q                 <= 2'h0;
      cfg_q                <= 2'h0;
      bypass_sw            <= '0;
      record_filter_switch <= 1'b0;
      dac_bias             <= 2'h0;
    end else begin
      pd_q  <= pd_ctl[PD_STATE_LSB +: 2];
      cfg_q <= cfg_reg[1:0];
      // Each left and right input bit closes its switch and opens the normal one.
      bypass_sw <= {byp_reg,
                    ~(byp_reg[0] | byp_reg[2]), ~(byp_reg[1] | byp_reg[3]),
                    ~(byp_reg[4] | byp_reg[6]), ~(byp_reg[5] | byp_reg[7])};
      // Filters are lent to the record path only while both converters are off.
      record_filter_switch <= rec_reg[BIT_REC_FILT] & ~dac_pwr[BIT_DAC_L] & ~dac_pwr[BIT_DAC_R];
      dac_bias <= cur_reg[DAC_CUR_LSB +: 2];
    end
  end

  // The driver bundle is gathered in one place so that no field has a second driver.
  assign hp = {drv_on, pd_q, cfg_q};

  // Per-driver power sequencing.
  for (genvar i = 0; i < NUM_DRV; i++) begin : g_drv
    odc_drv_e          st, next_st;     // Sequencer state.
    logic [CNT_W-1:0]  cnt, next_cnt;   // Delay and ramp step counter.
    logic [ATT_W-1:0]  att, next_att;   // Present attenuation.
    logic              en, next_en;     // Driver enable.
    logic [CNT_W-1:0]  target;          // Programmed delay in cycles.
    logic              fault;           // Shutdown demanded by a short.

    assign target = CNT_W'(DELAY_MS[pd_ctl[DELAY_LSB +: 3]]) * CNT_W'(DELAY_UNIT_CYC);
    assign fault  = sc_ctl[BIT_AUTO_OFF] & sflag[i];

    // Next state of the sequencer.
    always_comb begin
      next_st  = st;
      next_cnt = cnt;
      next_att = att;
      unique case (st)
        DRV_OFF: begin
          next_cnt = '0;
          if (pwr_reg[i]) begin
            next_st = DRV_WAIT;
          end
        end
        DRV_WAIT: begin
          if (!pwr_reg[i]) begin
            next_st = DRV_OFF;
          end else if (fault) begin
            next_st = DRV_FAULT;
          end else if (cnt >= target) begin
            next_cnt = '0;
            next_att = ramp_reg[BIT_RAMP_EN] ? RAMP_START : '0;
            next_st  = ramp_reg[BIT_RAMP_EN] ? DRV_RAMP : DRV_ON;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
        DRV_RAMP: begin
          if (!pwr_reg[i]) begin
            next_st = DRV_OFF;
          end else if (fault) begin
            next_st = DRV_FAULT;
          end else if (cnt == CNT_W'(RAMP_CYC - 1)) begin
            next_cnt = '0;
            next_att = att - 1'b1;
            if (att == ATT_W'(1)) begin
              next_st = DRV_ON;
            end
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
        DRV_ON: begin
          if (!pwr_reg[i]) begin
            next_st = DRV_OFF;
          end else if (fault) begin
            next_st = DRV_FAULT;
          end
        end
        DRV_FAULT: begin
          if (!pwr_reg[i]) begin
            next_st = DRV_OFF;
          end
        end
        default: next_st = DRV_OFF;
      endcase
      next_en = next_st == DRV_RAMP || next_st == DRV_ON;
    end

    // Sequencer registers.
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        st  <= DRV_OFF;
        cnt <= '0;
        att <= RAMP_START;
        en  <= 1'b0;
      end else begin
        st  <= next_st;
        cnt <= next_cnt;
        att <= next_att;
        en  <= next_en;
      end
    end
    assign hp_atten[i]  = att;
    assign drv_on[i]    = en;
  end

  // Per-pin function and interrupt pulse generation.
  for (genvar p = 0; p < NUM_GPIO; p++) begin : g_pin
    odc_pin_e           mode;           // Pin function.
    logic [NUM_SRC-1:0] mask;           // Sources routed to this pin.
    logic [CNT_W-1:0]   cnt, next_cnt;  // Pulse timing counter.
    logic               o, next_o;      // Pin level.
    logic               oe, next_oe;    // Pin drive enable.

    assign mode = odc_pin_e'(gcfg[p][1:0]);
    assign mask = gcfg[p][GPIO_MASK_LSB +: NUM_SRC];

    // Next pin level.
    always_comb begin
      next_cnt = '0;
      next_o   = 1'b0;
      next_oe  = 1'b1;
      unique case (mode)
        PIN_IN:  next_oe = 1'b0;
        PIN_OUT: next_o  = gcfg[p][GPIO_OUT_BIT];
        PIN_CLK: next_o  = int_clk;
        PIN_IRQ: begin
          if (gcfg[p][GPIO_TRAIN_BIT]) begin
            // A train repeats while any routed source stays latched.
            if (|(irq_stat & mask)) begin
              next_cnt = (cnt == CNT_W'(TRAIN_CYC - 1)) ? '0 : cnt + 1'b1;
              next_o   = cnt < CNT_W'(PULSE_CYC);
            end
          end else if (|(irq_set & mask)) begin
            next_cnt = CNT_W'(1);
            next_o   = 1'b1;
          end else if (cnt != '0 && cnt < CNT_W'(PULSE_CYC)) begin
            next_cnt = cnt + 1'b1;
            next_o   = 1'b1;
          end
        end
      endcase
    end

    // Pin registers.
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cnt <= '0;
        o   <= 1'b0;
        oe  <= 1'b0;
      end else begin
        cnt <= next_cnt;
        o   <= next_o;
        oe  <= next_oe;
      end
    end
    assign gpio_out[p] = o;
    assign gpio_oe[p]  = oe;
  end
endmodule

// [odc_chk.sv]
`timescale 1ns/100ps
module odc_chk (
  input wire logic                                        clk,
  input wire logic                                        rst_n,
  input wire logic                                        psel,
  input wire logic                                        penable,
  input wire logic                                        pwrite,
  input wire logic [odc_pkg::ADDR_W-1:0]                  paddr,
  input wire logic [odc_pkg::DATA_W-1:0]                  pwdata,
  input wire logic                                        pready,
  input wire logic [odc_pkg::NUM_GPIO-1:0]                gpio_oe,
  input wire odc_pkg::odc_hp_s                            hp,
  input wire logic [odc_pkg::NUM_DRV-1:0][odc_pkg::ATT_W-1:0] hp_atten,
  input wire odc_pkg::odc_byp_s                           bypass_sw,
  input wire logic                                        record_filter_switch,
  input wire logic [1:0]                                  dac_bias
);
  import odc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        wr;       // A write lands at this edge.
  logic [7:0]  wd;       // Low byte of the last landed write.
  logic [7:0]  next_wd;  // Next value of wd.
  logic [11:0] b;        // Switch vector as plain bits.
  assign wr = psel && penable && pready && pwrite && paddr[1:0] == 2'h0;
  assign b = bypass_sw;
  // Holds the written byte so later cycles can compare against it.
  always_comb begin
    next_wd = wr ? pwdata[7:0] : wd;
  end
  always_ff @(posedge clk) begin
    wd <= next_wd;
  end
  sequence s_wr(logic [IDX_W-1:0] i);
    wr && paddr[ADDR_W-1:2] == i;
  endsequence
  AST_PD: assert property (s_wr(IDX_PD_CTL) |-> ##[1:2] hp.pd_state == wd[1:0])
    else $error("pin state does not follow write");
  AST_FILT: assert property ((s_wr(IDX_DAC_PWR) ##1 wd[7:6] != 2'h0) |-> ##[0:1] !record_filter_switch)
    else $error("filter path open with a converter on");
  AST_BIAS: assert property (s_wr(IDX_DAC_CUR) |-> ##[1:2] dac_bias == wd[7:6])
    else $error("bias does not follow write");
  AST_LEFT: assert property (s_wr(IDX_BYPASS) |-> ##[1:2] b[7:4] == wd[3:0])
    else $error("left switches do not follow write");
  AST_RIGHT: assert property (s_wr(IDX_BYPASS) |-> ##[1:2] b[11:8] == wd[7:4])
    else $error("right switches do not follow write");
  AST_NORM: assert property ($past(rst_n) |-> b[3:0] == ~{b[4] | b[6], b[5] | b[7], b[8] | b[10], b[9] | b[11]})
    else $error("normal switch not opposite to input switches");
  AST_ATT: assert property (hp.en[0] && $past(hp.en[0]) && !$stable(hp_atten[0]) |-> hp_atten[0] == $past(hp_atten[0]) - 6'h01)
    else $error("attenuation step is not one");
  AST_OE: assert property (s_wr(IDX_GPIO0) |-> ##[1:2] gpio_oe[0] == (wd[1:0] != 2'h0))
    else $error("pin enable does not follow mode");
endmodule
bind odc_top odc_chk u_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .gpio_oe(gpio_oe), .hp(hp), .hp_atten(hp_atten),
  .bypass_sw(bypass_sw), .record_filter_switch(record_filter_switch), .dac_bias(dac_bias)
);

// [odc_top_tb_top.sv]
`timescale 1ns/100ps
module odc_top_tb_top;
  import odc_pkg::*;
  logic                          clk, rst_n, psel, penable, pwrite, pready, pslverr, last_err, rfs, int_clk;
  logic [ADDR_W-1:0]             paddr;
  logic [DATA_W-1:0]             pwdata, prdata, rv;
  logic [1:0]                    gpio_in, gpio_out, gpio_oe, dac_bias;
  odc_det_s                      det;
  odc_hp_s                       hp;
  logic [NUM_DRV-1:0][ATT_W-1:0] hp_atten;
  odc_byp_s                      bypass_sw;
  int                            error_cnt, checks, n;
  // A delay unit of four cycles keeps the power-up wait short.
  odc_top #(.DELAY_UNIT_CYC(4)) uut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .det(det),
    .gpio_in(gpio_in), .int_clk(int_clk), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .hp(hp),
    .hp_atten(hp_atten), .bypass_sw(bypass_sw), .record_filter_switch(rfs), .dac_bias(dac_bias)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // One APB transfer; one idle edge follows so a new setup never collides.
  task automatic apb(input logic w, input logic [IDX_W-1:0] i, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Counts edges until the first pin reaches level v.
  task automatic wpin(input logic v);
    n = 0;
    while (gpio_out[0] !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic t_regs();
    apb(1'b0, IDX_RAMP, 0);
    chk("ramp", rv, {24'h0, RST_RAMP});
    apb(1'b0, IDX_DAC_CUR, 0);
    chk("bias", rv, 0);
    chk("sw", bypass_sw, 12'h00f);
    apb(1'b0, 10'h3ff, 0);
    chk("unmap", {rv[30:0], last_err}, 1);
    $display("regs done");
  endtask
  task automatic t_sw();
    logic [7:0] d;
    for (int k = 0; k < 9; k++) begin
      d = 8'h01 << k;
      apb(1'b1, IDX_BYPASS, {24'h0, d});
      apb(1'b1, IDX_DAC_CUR, k << 6);
      apb(1'b1, IDX_PD_CTL, k % 3);
      // The pin state is registered once more after the control byte lands.
      @(posedge clk);
      chk("byp", bypass_sw, {d, ~(d[0] | d[2]), ~(d[1] | d[3]), ~(d[4] | d[6]), ~(d[5] | d[7])});
      chk("dbias", dac_bias, k % 4);
      chk("pd", hp.pd_state, k % 3);
    end
    apb(1'b1, IDX_DAC_PWR, 32'hc0);
    apb(1'b1, IDX_REC_FILT, 32'h08);
    @(posedge clk);
    chk("rec_dac", rfs, 0);
    apb(1'b1, IDX_DAC_PWR, 32'h00);
    @(posedge clk);
    chk("rec_on", rfs, 1);
    apb(1'b1, IDX_DAC_PWR, 32'h40);
    @(posedge clk);
    chk("rec_r", rfs, 0);
    $display("switch done");
  endtask
  task automatic t_drv();
    apb(1'b1, IDX_PD_CTL, 32'h10);
    apb(1'b1, IDX_HP_CFG, {30'h0, CFG_SE});
    apb(1'b1, IDX_HP_PWR, 32'h1);
    chk("wait", hp.en[0], 0);
    chk("cfg", hp.cfg_type, CFG_SE);
    n = 0;
    while (hp.en[0] !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("delay", n > 1 && n < 8, 1);
    chk("att0", hp_atten[0], 6'h3f);
    repeat (RAMP_CYC + 10) @(posedge clk);
    chk("att1", hp_atten[0], 6'h3e);
    apb(1'b1, IDX_SHORT_CTL, 32'h06);
    det.short_det[0] <= 1'b1;
    repeat (4) @(posedge clk);
    det.short_det[0] <= 1'b0;
    apb(1'b0, IDX_SHORT_STAT, 0);
    chk("flag", rv[3:0], 4'h1);
    chk("off", hp.en[0], 0);
    apb(1'b1, IDX_HP_PWR, 32'h0);
    apb(1'b1, IDX_HP_PWR, 32'h1);
    apb(1'b0, IDX_SHORT_STAT, 0);
    chk("clr", rv[3:0], 4'h0);
    $display("driver done");
  endtask
  task automatic t_irq();
    apb(1'b0, IDX_IRQ_STAT, 0);
    apb(1'b1, IDX_GPIO0, 32'h13);
    det.jack <= 1'b1;
    det.hs_type <= HS_MONO;
    wpin(1'b1);
    wpin(1'b0);
    chk("pulse", n, PULSE_CYC);
    apb(1'b0, IDX_IRQ_STAT, 0);
    chk("src", rv[0], 1);
    apb(1'b0, IDX_IRQ_STAT, 0);
    chk("rdclr", rv[0], 0);
    apb(1'b0, IDX_HEADSET, 0);
    chk("type", rv[1:0], HS_MONO);
    apb(1'b1, IDX_HP_CFG, 32'h3);
    apb(1'b0, IDX_HEADSET, 0);
    chk("ac", rv[1:0], HS_STEREO);
    gpio_in <= 2'b10;
    // The pin level is sampled one edge before it can be read back.
    @(posedge clk);
    apb(1'b0, IDX_GPIO0 + 10'h001, 0);
    chk("pin_in", rv[8], 1);
    apb(1'b1, IDX_GPIO0, 32'h1b);
    det.jack <= 1'b0;
    wpin(1'b1);
    wpin(1'b0);
    wpin(1'b1);
    chk("train", n, TRAIN_CYC - PULSE_CYC);
    apb(1'b0, IDX_IRQ_STAT, 0);
    wpin(1'b0);
    wpin(1'b1);
    chk("stop", n, 3000);
    $display("irq done");
  endtask
  initial begin
    {rst_n, psel, penable, pwrite, int_clk, paddr, pwdata, gpio_in, det} = '0;
    error_cnt = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_sw();
    t_drv();
    t_irq();
    close_out();
  end
endmodule
